// file: hw/irq_pin_regs.svh
// Register offsets, field positions and reset values of the interrupt pin block.
`ifndef IRQ_PIN_REGS_SVH
`define IRQ_PIN_REGS_SVH
`define FIRST_IRQ_PIN_IO_CFG_OFS     8'h53
`define SECOND_IRQ_PIN_IO_CFG_OFS    8'h54
`define IRQ_HOLD_MODE_CFG_OFS        8'h55
`define FIRST_PIN_FEATURE_ROUTE_OFS  8'h56
`define SECOND_PIN_FEATURE_ROUTE_OFS 8'h57
`define DATA_EVENT_ROUTE_OFS         8'h58
`define IO_CFG_RST                   8'h00
`define HOLD_MODE_RST                8'h00
`define ROUTE_RST                    8'h00
`define IO_CFG_MASK                  8'h1F
`define HOLD_MODE_MASK               8'h01
`define DATA_ROUTE_MASK              8'h77
`define IO_EDGE_BIT                  0
`define IO_LEVEL_BIT                 1
`define IO_DRAIN_BIT                 2
`define IO_OUT_EN_BIT                3
`define IO_IN_EN_BIT                 4
`define HOLD_LATCH_BIT               0
`define ROUTE_FULL_BIT               0
`define ROUTE_WATERMARK_BIT          1
`define ROUTE_NEWDATA_BIT            2
`define ROUTE_SECOND_SHIFT           4
`endif

// file: hw/irq_pin_pkg.sv
// Types shared by the interrupt pin block.
package irq_pin_pkg;
  typedef struct packed {
    logic inEn;
    logic outEn;
    logic drainModeSel;
    logic activeHigh;
    logic edgeTrig;
  } pin_cfg_t;

  typedef struct packed {
    logic newData;
    logic watermark;
    logic full;
  } event_set_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage : irq_pin_pkg

// file: hw/irq_pin_driver.sv
// One interrupt pin: event hold, polarity, drive mode, enables and input sensing.
`timescale 1ns/1ps
module irq_pin_driver (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire irq_pin_pkg::pin_cfg_t cfg,
  input  wire logic                  latchMode,
  input  wire logic                  eventAny,
  input  wire logic                  clearHold,
  input  wire logic                  pinIn,
  output logic                       pinOut,
  output logic                       pinOeN,
  output logic                       senseEvent
);
  logic holdQ, holdD;
  logic outQ, outD;
  logic oeNQ, oeND;
  logic syncAQ, syncBQ, syncCQ;
  logic senseQ, senseD;
  logic active;

  always_comb
  begin
    holdD = holdQ;
    if (!latchMode)
      holdD = 1'b0;
    else if (eventAny)
      holdD = 1'b1;
    else if (clearHold)
      holdD = 1'b0;
    active = eventAny | holdD;
    outD = cfg.activeHigh ? active : ~active;
    if (!cfg.outEn)
      oeND = 1'b1;
    else if (cfg.drainModeSel)
      oeND = ~(outD == cfg.activeHigh);
    else
      oeND = 1'b0;
    senseD = 1'b0;
    if (cfg.inEn)
    begin
      if (cfg.edgeTrig)
        senseD = (syncBQ == cfg.activeHigh) && (syncCQ != cfg.activeHigh);
      else
        senseD = (syncBQ == cfg.activeHigh);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      holdQ  <= 1'b0;
      outQ   <= 1'b1;
      oeNQ   <= 1'b1;
      syncAQ <= 1'b0;
      syncBQ <= 1'b0;
      syncCQ <= 1'b0;
      senseQ <= 1'b0;
    end
    else
    begin
      holdQ  <= holdD;
      outQ   <= outD;
      oeNQ   <= oeND;
      syncAQ <= pinIn;
      syncBQ <= syncAQ;
      syncCQ <= syncBQ;
      senseQ <= senseD;
    end
  end

  assign pinOut     = outQ;
  assign pinOeN     = oeNQ;
  assign senseEvent = senseQ;

  offDrive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cfg.outEn |=> pinOeN) else $error("Disabled pin is driven.");
  drainIdle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $stable(cfg) && cfg.outEn && cfg.drainModeSel && !eventAny && !holdD |=> pinOeN)
    else $error("Open drain drives idle level.");
  polarity_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventAny |=> pinOut == $past(cfg.activeHigh)) else $error("Wrong active level.");
  pushPull_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cfg.outEn && !cfg.drainModeSel |=> !pinOeN) else $error("Push-pull pin released.");
endmodule : irq_pin_driver

// file: hw/irq_pin_config_and_mapping.sv
// Interrupt pin configuration registers and event routing onto two pins.
`timescale 1ns/1ps
`include "irq_pin_regs.svh"
// Summary of operation
// - Bit 0 of each pin control register picks level (0) or edge (1) sensing of the pin input.
// - Bit 1 makes the pin active low (0) or active high (1).
// - Bit 2 picks push-pull (0) or open-drain (1) drive.
// - Bit 3 disables (0) or enables (1) the pin output.
// - Bit 4 disables (0) or enables (1) the pin input.
// - The second pin control register has the same fields and acts on the second pin alone.
// - Both pin control registers reset to zero and bits 7 to 5 read as zero.
// - Bit 0 of the hold mode register selects pulsed (0) or latched (1) signalling, reset zero.
// - Route bits 0, 1 and 2 send full, watermark and new data events to the first pin.
// - Route bits 4, 5 and 6 send the same events to the second pin; bits 3 and 7 read zero.
// - Feature route registers sit at 0x56 and 0x57 per pin and reset to zero.
// - The watermark event comes from a fill threshold held outside this block.
// - The full event comes from the buffer whose stop-on-full option lives outside.
module irq_pin_config_and_mapping (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire irq_pin_pkg::reg_req_t   regReq,
  output logic [7:0]                   regRdata,
  input  wire irq_pin_pkg::event_set_t dataEvents,
  input  wire logic [7:0]              featureEvents,
  input  wire logic                    statusRead,
  input  wire logic                    firstIrqPinIn,
  output logic                         firstIrqPinOut,
  output logic                         firstIrqPinOeN,
  input  wire logic                    secondIrqPinIn,
  output logic                         secondIrqPinOut,
  output logic                         secondIrqPinOeN,
  output logic [1:0]                   pinSense
);
  logic [7:0] firstCfgQ, firstCfgD;
  logic [7:0] secondCfgQ, secondCfgD;
  logic [7:0] holdQ, holdD;
  logic [7:0] featFirstQ, featFirstD;
  logic [7:0] featSecondQ, featSecondD;
  logic [7:0] dataRouteQ, dataRouteD;
  logic [7:0] rdataQ, rdataD;
  logic [1:0] pinAny;
  logic [1:0] senseRaw;
  logic [1:0] senseQ;
  logic       latchMode;

  always_comb
  begin
    firstCfgD   = firstCfgQ;
    secondCfgD  = secondCfgQ;
    holdD       = holdQ;
    featFirstD  = featFirstQ;
    featSecondD = featSecondQ;
    dataRouteD  = dataRouteQ;
    rdataD      = rdataQ;
    if (regReq.wr)
    begin
      case (regReq.addr)
        `FIRST_IRQ_PIN_IO_CFG_OFS:     firstCfgD   = regReq.wdata & `IO_CFG_MASK;
        `SECOND_IRQ_PIN_IO_CFG_OFS:    secondCfgD  = regReq.wdata & `IO_CFG_MASK;
        `IRQ_HOLD_MODE_CFG_OFS:        holdD       = regReq.wdata & `HOLD_MODE_MASK;
        `FIRST_PIN_FEATURE_ROUTE_OFS:  featFirstD  = regReq.wdata;
        `SECOND_PIN_FEATURE_ROUTE_OFS: featSecondD = regReq.wdata;
        `DATA_EVENT_ROUTE_OFS:         dataRouteD  = regReq.wdata & `DATA_ROUTE_MASK;
        default:                       dataRouteD  = dataRouteQ;
      endcase
    end
    if (regReq.rd)
    begin
      case (regReq.addr)
        `FIRST_IRQ_PIN_IO_CFG_OFS:     rdataD = firstCfgQ;
        `SECOND_IRQ_PIN_IO_CFG_OFS:    rdataD = secondCfgQ;
        `IRQ_HOLD_MODE_CFG_OFS:        rdataD = holdQ;
        `FIRST_PIN_FEATURE_ROUTE_OFS:  rdataD = featFirstQ;
        `SECOND_PIN_FEATURE_ROUTE_OFS: rdataD = featSecondQ;
        `DATA_EVENT_ROUTE_OFS:         rdataD = dataRouteQ;
        default:                       rdataD = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      firstCfgQ   <= `IO_CFG_RST;
      secondCfgQ  <= `IO_CFG_RST;
      holdQ       <= `HOLD_MODE_RST;
      featFirstQ  <= `ROUTE_RST;
      featSecondQ <= `ROUTE_RST;
      dataRouteQ  <= `ROUTE_RST;
      rdataQ      <= 8'h00;
      senseQ      <= 2'h0;
    end
    else
    begin
      firstCfgQ   <= firstCfgD;
      secondCfgQ  <= secondCfgD;
      holdQ       <= holdD;
      featFirstQ  <= featFirstD;
      featSecondQ <= featSecondD;
      dataRouteQ  <= dataRouteD;
      rdataQ      <= rdataD;
      senseQ      <= senseRaw;
    end
  end

  assign latchMode = holdQ[`HOLD_LATCH_BIT];
  assign regRdata  = rdataQ;
  assign pinSense  = senseQ;

  // Watermark and full events arrive already qualified by the buffer's threshold and stop option.
  always_comb
  begin
    pinAny[0] = (dataEvents.full      & dataRouteQ[`ROUTE_FULL_BIT])
              | (dataEvents.watermark & dataRouteQ[`ROUTE_WATERMARK_BIT])
              | (dataEvents.newData   & dataRouteQ[`ROUTE_NEWDATA_BIT])
              | (|(featureEvents & featFirstQ));
    pinAny[1] = (dataEvents.full      & dataRouteQ[`ROUTE_SECOND_SHIFT + `ROUTE_FULL_BIT])
              | (dataEvents.watermark & dataRouteQ[`ROUTE_SECOND_SHIFT + `ROUTE_WATERMARK_BIT])
              | (dataEvents.newData   & dataRouteQ[`ROUTE_SECOND_SHIFT + `ROUTE_NEWDATA_BIT])
              | (|(featureEvents & featSecondQ));
  end

  irq_pin_driver firstDriver (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .cfg        (irq_pin_pkg::pin_cfg_t'(firstCfgQ[4:0])),
    .latchMode  (latchMode),
    .eventAny   (pinAny[0]),
    .clearHold  (statusRead),
    .pinIn      (firstIrqPinIn),
    .pinOut     (firstIrqPinOut),
    .pinOeN     (firstIrqPinOeN),
    .senseEvent (senseRaw[0])
  );

  irq_pin_driver secondDriver (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .cfg        (irq_pin_pkg::pin_cfg_t'(secondCfgQ[4:0])),
    .latchMode  (latchMode),
    .eventAny   (pinAny[1]),
    .clearHold  (statusRead),
    .pinIn      (secondIrqPinIn),
    .pinOut     (secondIrqPinOut),
    .pinOeN     (secondIrqPinOeN),
    .senseEvent (senseRaw[1])
  );

  reservedZero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    firstCfgQ[7:5] == 3'h0 && secondCfgQ[7:5] == 3'h0 && dataRouteQ[7] == 1'b0 && dataRouteQ[3] == 1'b0)
    else $error("Reserved bits set.");
  routeOr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataEvents.newData && dataRouteQ[`ROUTE_NEWDATA_BIT] |-> pinAny[0]) else $error("Route lost.");
  routeSecond_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataEvents.full && dataRouteQ[`ROUTE_SECOND_SHIFT] |-> pinAny[1]) else $error("Route lost.");
  holdWrite_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    regReq.wr && regReq.addr == `IRQ_HOLD_MODE_CFG_OFS |=> holdQ == ($past(regReq.wdata) & 8'h01))
    else $error("Hold write lost.");
  featWrite_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    regReq.wr && regReq.addr == 8'h57 |=> featSecondQ == $past(regReq.wdata))
    else $error("Feature route write lost.");

  // Register accesses the properties below check: writes to four registers, the route read and unmapped reads.
  sequence firstCfgWrite_s;
    regReq.wr && regReq.addr == `FIRST_IRQ_PIN_IO_CFG_OFS;
  endsequence
  sequence secondCfgWrite_s;
    regReq.wr && regReq.addr == `SECOND_IRQ_PIN_IO_CFG_OFS;
  endsequence
  sequence routeWrite_s;
    regReq.wr && regReq.addr == `DATA_EVENT_ROUTE_OFS;
  endsequence
  sequence featFirstWrite_s;
    regReq.wr && regReq.addr == `FIRST_PIN_FEATURE_ROUTE_OFS;
  endsequence
  sequence routeRead_s;
    regReq.rd && regReq.addr == `DATA_EVENT_ROUTE_OFS;
  endsequence
  sequence unmappedRead_s;
    regReq.rd && (regReq.addr < `FIRST_IRQ_PIN_IO_CFG_OFS || regReq.addr > `DATA_EVENT_ROUTE_OFS);
  endsequence

  firstCfgStore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    firstCfgWrite_s |=> firstCfgQ == ($past(regReq.wdata) & `IO_CFG_MASK))
    else $error("First pin setup write lost.");
  secondCfgStore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    secondCfgWrite_s |=> secondCfgQ == ($past(regReq.wdata) & `IO_CFG_MASK))
    else $error("Second pin setup write lost.");
  routeStore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    routeWrite_s |=> dataRouteQ == ($past(regReq.wdata) & `DATA_ROUTE_MASK))
    else $error("Data route write lost.");
  featFirstStore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    featFirstWrite_s |=> featFirstQ == $past(regReq.wdata))
    else $error("First feature route write lost.");
  routeReadback_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    routeRead_s |=> regRdata == $past(dataRouteQ))
    else $error("Data route read wrong.");
  unmappedZero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    unmappedRead_s |=> regRdata == 8'h00)
    else $error("Unmapped read not zero.");
  routeWatermark_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataEvents.watermark && dataRouteQ[`ROUTE_WATERMARK_BIT] |-> pinAny[0])
    else $error("Watermark route lost.");
  routeNewSecond_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataEvents.newData && dataRouteQ[`ROUTE_SECOND_SHIFT + `ROUTE_NEWDATA_BIT] |-> pinAny[1])
    else $error("New data route lost.");
  featureOr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (|(featureEvents & featFirstQ)) |-> pinAny[0])
    else $error("Feature source not combined.");
  fullFirst_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataEvents.full && dataRouteQ[`ROUTE_FULL_BIT] |-> pinAny[0])
    else $error("Full route lost.");
  quietPins_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataRouteQ == 8'h00 && featFirstQ == 8'h00 && featSecondQ == 8'h00 |-> pinAny == 2'h0)
    else $error("Unrouted pin active.");
endmodule : irq_pin_config_and_mapping

// file: bench/host_irq_inputs.sv
// Model of the host interrupt inputs with a pull-up on the shared line.
`timescale 1ns/1ps
module host_irq_inputs (
  input  wire logic pinOut,
  input  wire logic pinOeN,
  input  wire logic hostDrive,
  input  wire logic hostLevel,
  output logic      pinWire
);
  // A released line floats to the pull-up level unless the host drives it.
  assign pinWire = !pinOeN ? pinOut : (hostDrive ? hostLevel : 1'b1);
endmodule : host_irq_inputs

// file: bench/testbench.sv
// Self-checking testbench of the interrupt pin block.
`timescale 1ns/1ps
module testbench;
  logic                    core_clk, sys_rst, statusRead, drv1, lvl1, drv2, lvl2;
  irq_pin_pkg::reg_req_t   regReq;
  irq_pin_pkg::event_set_t dataEvents;
  logic [7:0]              featureEvents, regRdata, rv;
  logic                    out1, oen1, out2, oen2, wire1, wire2;
  logic [1:0]              pinSense;
  int                      failures, comparisons, n;
  logic [7:0] ofs [6] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58};
  logic [7:0] msk [6] = '{8'h1F, 8'h1F, 8'h01, 8'hFF, 8'hFF, 8'h77};
  logic [7:0] cfgs [5] = '{8'h08, 8'h0C, 8'h0E, 8'h0A, 8'h00};
  logic [1:0] idle [5] = '{2'b10, 2'b11, 2'b11, 2'b00, 2'b11};
  logic [1:0] act  [5] = '{2'b00, 2'b00, 2'b10, 2'b10, 2'b11};

  irq_pin_config_and_mapping u_irq_pin_config_and_mapping (.core_clk(core_clk), .sys_rst(sys_rst),
    .regReq(regReq), .regRdata(regRdata), .dataEvents(dataEvents), .featureEvents(featureEvents),
    .statusRead(statusRead), .firstIrqPinIn(wire1), .firstIrqPinOut(out1), .firstIrqPinOeN(oen1),
    .secondIrqPinIn(wire2), .secondIrqPinOut(out2), .secondIrqPinOeN(oen2), .pinSense(pinSense));
  host_irq_inputs u_host_irq_inputs (.pinOut(out1), .pinOeN(oen1), .hostDrive(drv1), .hostLevel(lvl1),
    .pinWire(wire1));
  host_irq_inputs u_host_irq_inputs_2 (.pinOut(out2), .pinOeN(oen2), .hostDrive(drv2), .hostLevel(lvl2),
    .pinWire(wire2));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : tick

  task wrReg(input logic [7:0] a, input logic [7:0] d);
    regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    regReq = '0;
    tick(1);
  endtask : wrReg

  task rdReg(input logic [7:0] a, output logic [7:0] d);
    regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    d = regRdata;
    regReq = '0;
    tick(1);
  endtask : rdReg

  initial
  begin
    #2_000_000;
    failures++;
    results();
  end

  initial
  begin
    failures = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    statusRead = 1'b0;
    regReq = '0;
    dataEvents = '0;
    featureEvents = 8'h00;
    {drv1, lvl1, drv2, lvl2} = 4'h0;
    repeat (20) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    tick(1);
    check({6'h00, oen1, oen2}, 8'h03);
    for (int i = 0; i < 6; i++)
    begin
      rdReg(ofs[i], rv);
      check(rv, 8'h00);
      wrReg(ofs[i], 8'hFF);
      rdReg(ofs[i], rv);
      check(rv, msk[i]);
      wrReg(ofs[i], 8'h00);
    end
    wrReg(8'h52, 8'hFF);
    rdReg(8'h52, rv);
    check(rv, 8'h00);
    for (int p = 0; p < 2; p++)
      for (int e = 0; e < 3; e++)
      begin
        wrReg(8'h53 + 8'(p), 8'h0A);
        wrReg(8'h58, 8'(1 << (e + 4 * p)));
        dataEvents = 3'(7 - (1 << e));
        tick(3);
        check({4'h0, out1, oen1, out2, oen2}, p ? 8'h0C : 8'h03);
        dataEvents = 3'(1 << e) | 3'(7 - (1 << e));
        tick(3);
        check({4'h0, out1, oen1, out2, oen2}, p ? 8'h0E : 8'h0B);
        dataEvents = '0;
        wrReg(8'h53 + 8'(p), 8'h00);
      end
    wrReg(8'h58, 8'h04);
    for (int i = 0; i < 5; i++)
    begin
      wrReg(8'h53, cfgs[i]);
      tick(2);
      check({6'h00, wire1, oen1}, {6'h00, idle[i]});
      dataEvents.newData = 1'b1;
      tick(3);
      check({6'h00, wire1, oen1}, {6'h00, act[i]});
      dataEvents.newData = 1'b0;
    end
    wrReg(8'h53, 8'h0A);
    wrReg(8'h55, 8'h01);
    dataEvents.full = 1'b1;
    tick(1);
    dataEvents.full = 1'b0;
    wrReg(8'h58, 8'h01);
    dataEvents.full = 1'b1;
    tick(1);
    dataEvents.full = 1'b0;
    tick(4);
    check({7'h00, out1}, 8'h01);
    statusRead = 1'b1;
    tick(1);
    statusRead = 1'b0;
    tick(3);
    check({7'h00, out1}, 8'h00);
    wrReg(8'h55, 8'h00);
    wrReg(8'h58, 8'h00);
    wrReg(8'h57, 8'h80);
    wrReg(8'h54, 8'h0A);
    featureEvents = 8'h80;
    tick(3);
    check({6'h00, out2, out1}, 8'h02);
    featureEvents = 8'h00;
    wrReg(8'h53, 8'h10);
    wrReg(8'h54, 8'h12);
    {drv1, lvl1, drv2, lvl2} = 4'hB;
    tick(6);
    check({6'h00, pinSense}, 8'h03);
    wrReg(8'h53, 8'h00);
    tick(5);
    check({6'h00, pinSense}, 8'h02);
    wrReg(8'h53, 8'h11);
    drv1 = 1'b0;
    tick(6);
    n = 0;
    drv1 = 1'b1;
    for (int c = 0; c < 10; c++)
    begin
      tick(1);
      n += int'(pinSense[0] === 1'b1);
    end
    check(8'(n), 8'h01);
    results();
  end
endmodule : testbench
